/* File: rtl/pbd_pkg.sv */
/*
  package for the protection blocking delays block: widths, default delays,
  timebase figures and the carrier structs.
  assumes a 40 MHz system clock and sensor words already scaled to threshold units.
*/
package pbd_pkg;

  localparam int unsigned CLOCK_PERIOD_NS  = 25;
  localparam int unsigned SECOND_NS        = 1000000000;
  localparam int unsigned TICKS_PER_SECOND = SECOND_NS / CLOCK_PERIOD_NS;

  localparam int unsigned DELAY_WIDTH   = 6;
  localparam int unsigned MEASURE_WIDTH = 16;
  localparam int unsigned SYNC_DEPTH    = 3;
  localparam int unsigned BIN_INPUTS    = 4;
  localparam int unsigned RUN_GROUPS    = 3;
  localparam int unsigned RUN_SENSES    = 3;
  localparam int unsigned FORCE_INPUTS  = 2;

  localparam logic [DELAY_WIDTH-1:0] DELAY_MAX_S = 6'h3C;

  localparam logic [DELAY_WIDTH-1:0] RUN_GROUP_A_DEFAULT_S = 6'h0A;
  localparam logic [DELAY_WIDTH-1:0] RUN_GROUP_B_DEFAULT_S = 6'h14;
  localparam logic [DELAY_WIDTH-1:0] RUN_GROUP_C_DEFAULT_S = 6'h1E;
  localparam logic [DELAY_WIDTH-1:0] FILTER_A_DEFAULT_S    = 6'h01;
  localparam logic [DELAY_WIDTH-1:0] FILTER_B_DEFAULT_S    = 6'h05;
  localparam logic [DELAY_WIDTH-1:0] FILTER_C_DEFAULT_S    = 6'h0A;
  localparam logic [DELAY_WIDTH-1:0] FORCED_A_DEFAULT_S    = 6'h00;
  localparam logic [DELAY_WIDTH-1:0] FORCED_B_DEFAULT_S    = 6'h00;

  localparam logic [1:0] FILTER_SEL_A = 2'h0;
  localparam logic [1:0] FILTER_SEL_B = 2'h1;

  typedef struct packed {
    logic [DELAY_WIDTH-1:0] run_group_a_delay;
    logic [DELAY_WIDTH-1:0] run_group_b_delay;
    logic [DELAY_WIDTH-1:0] run_group_c_delay;
    logic [DELAY_WIDTH-1:0] input_filter_delay_a;
    logic [DELAY_WIDTH-1:0] input_filter_delay_b;
    logic [DELAY_WIDTH-1:0] input_filter_delay_c;
    logic [DELAY_WIDTH-1:0] forced_inhibit_delay_a;
    logic [DELAY_WIDTH-1:0] forced_inhibit_delay_b;
  } pbd_delays_type;

  localparam pbd_delays_type DELAYS_DEFAULT = '{
    run_group_a_delay:      RUN_GROUP_A_DEFAULT_S,
    run_group_b_delay:      RUN_GROUP_B_DEFAULT_S,
    run_group_c_delay:      RUN_GROUP_C_DEFAULT_S,
    input_filter_delay_a:   FILTER_A_DEFAULT_S,
    input_filter_delay_b:   FILTER_B_DEFAULT_S,
    input_filter_delay_c:   FILTER_C_DEFAULT_S,
    forced_inhibit_delay_a: FORCED_A_DEFAULT_S,
    forced_inhibit_delay_b: FORCED_B_DEFAULT_S
  };

  typedef struct packed {
    logic [MEASURE_WIDTH-1:0] speed;
    logic [MEASURE_WIDTH-1:0] oil_pressure;
    logic [MEASURE_WIDTH-1:0] coolant_pressure;
  } pbd_measure_type;

  typedef struct packed {
    logic [MEASURE_WIDTH-1:0] start_speed_threshold;
    logic [MEASURE_WIDTH-1:0] start_oil_pressure_threshold;
    logic [MEASURE_WIDTH-1:0] start_coolant_pressure_threshold;
  } pbd_threshold_type;

endpackage

/* File: rtl/pbd_delay_timer.sv */
/*
  one delay channel: output goes high once arm has stayed high for delay seconds,
  and drops the cycle after arm drops.
  assumes arm is already synchronous to clock.
*/
`timescale 1ns/100ps
module pbd_delay_timer #(
  parameter int unsigned SEC_TICKS = pbd_pkg::TICKS_PER_SECOND
) (
  input  wire logic                             clock,
  input  wire logic                             reset,
  input  wire logic                             arm,
  input  wire logic [pbd_pkg::DELAY_WIDTH-1:0]  delay,
  output logic                                  done
);

  localparam int unsigned CW = (SEC_TICKS > 1) ? $clog2(SEC_TICKS) : 1;
  localparam logic [CW-1:0] LAST_TICK = CW'(SEC_TICKS - 1);

  logic [CW-1:0]                   cycle_cnt;
  logic [pbd_pkg::DELAY_WIDTH-1:0] sec_cnt;
  wire                             sec_wrap;
  wire [pbd_pkg::DELAY_WIDTH-1:0]  limit;
  wire [CW-1:0]                    next_cycle_cnt;
  wire [pbd_pkg::DELAY_WIDTH-1:0]  next_sec_cnt;
  wire                             next_done;

  // settings above the range clamp to the maximum
  assign limit          = (delay > pbd_pkg::DELAY_MAX_S) ? pbd_pkg::DELAY_MAX_S : delay;
  assign sec_wrap       = (cycle_cnt == LAST_TICK);
  // counters restart while arm is low
  assign next_cycle_cnt = !arm ? '0 : (sec_wrap ? '0 : cycle_cnt + CW'(1));
  assign next_sec_cnt   = !arm ? '0 : ((sec_wrap && sec_cnt != pbd_pkg::DELAY_MAX_S) ? sec_cnt + 6'h01 : sec_cnt);
  assign next_done      = arm && (sec_cnt >= limit);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cycle_cnt <= '0;
      sec_cnt   <= '0;
      done      <= 1'b0;
    end else begin
      cycle_cnt <= next_cycle_cnt;
      sec_cnt   <= next_sec_cnt;
      done      <= next_done;
    end
  end

  // helper: cycles arm has been held, saturating
  logic [31:0] held_cycles;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      held_cycles <= '0;
    end else if (!arm) begin
      held_cycles <= '0;
    end else if (held_cycles != 32'hFFFFFFFF) begin
      held_cycles <= held_cycles + 32'h1;
    end
  end

  a_done_not_early: assert property (@(posedge clock) disable iff (reset)
    done |-> (64'(held_cycles) + 64'h1 >= 64'(limit) * 64'(SEC_TICKS)))
    else $error("delay output rose before its delay elapsed");

  a_done_drop: assert property (@(posedge clock) disable iff (reset)
    !arm |=> !done)
    else $error("delay output stayed high after arm fell");

endmodule

/* File: rtl/pbd_top.sv */
/*
  protection qualification: engine running detection, running-only alarm group
  hold-off, binary input protection filters and forced inhibit channels.
  assumes sensor words are synchronous to clock; all contact inputs are raw pins.
*/
// Functional notes
// - running-only groups held off until running plus delay
// - group a delay 0..60 s, default 10
// - group b own delay, default 20 s
// - group c own delay, default 30 s
// - running when speed or oil above start threshold
// - coolant threshold counts only for propulsion application
// - any run sense input also means running
// - protection active after input closed beyond filter
// - three filter delays 0..60 s, defaults 1,5,10
// - filter only for protections, not logical function
// - forced inhibit a active after delay once opened
// - forced inhibit b same, own delay, default 0
// - forced inhibit removed at once on closing
// - forced inhibit ignores engine running state
`timescale 1ns/100ps
module pbd_top #(
  parameter int unsigned SEC_TICKS = pbd_pkg::TICKS_PER_SECOND
) (
  input  wire logic                                 clock,
  input  wire logic                                 reset,
  input  pbd_pkg::pbd_measure_type                  measure,
  input  pbd_pkg::pbd_threshold_type                thresholds,
  input  pbd_pkg::pbd_delays_type                   delays,
  input  wire logic                                 propulsion_application,
  input  wire logic [pbd_pkg::RUN_SENSES-1:0]       run_sense_input,
  input  wire logic [pbd_pkg::BIN_INPUTS-1:0]       bin_input,
  input  wire logic [pbd_pkg::BIN_INPUTS-1:0]       bin_is_protection,
  input  wire logic [2*pbd_pkg::BIN_INPUTS-1:0]     bin_filter_select,
  input  wire logic [pbd_pkg::FORCE_INPUTS-1:0]     forced_inhibit_input,
  output logic                                      engine_running,
  output logic [pbd_pkg::RUN_GROUPS-1:0]            run_group_enable,
  output logic [pbd_pkg::BIN_INPUTS-1:0]            bin_protection_active,
  output logic [pbd_pkg::BIN_INPUTS-1:0]            bin_logic_level,
  output logic [pbd_pkg::FORCE_INPUTS-1:0]          forced_inhibit_active
);

  localparam int unsigned NPIN = pbd_pkg::RUN_SENSES + pbd_pkg::BIN_INPUTS + pbd_pkg::FORCE_INPUTS;
  // force pins rest closed in reset, so no inhibit fires before the pin is seen
  localparam logic [NPIN-1:0] PIN_RESET = {{pbd_pkg::FORCE_INPUTS{1'b1}},
                                           {(pbd_pkg::RUN_SENSES + pbd_pkg::BIN_INPUTS){1'b0}}};

  // pin synchronisers: three stages, change accepted when stages two and three agree
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_level;
  wire  [NPIN-1:0] pin_raw;
  wire  [NPIN-1:0] next_pin_level;

  assign pin_raw        = {forced_inhibit_input, bin_input, run_sense_input};
  assign next_pin_level = (pin_s2 & pin_s3) | (pin_level & (pin_s2 | pin_s3));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_s1    <= PIN_RESET;
      pin_s2    <= PIN_RESET;
      pin_s3    <= PIN_RESET;
      pin_level <= PIN_RESET;
    end else begin
      pin_s1    <= pin_raw;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_level <= next_pin_level;
    end
  end

  wire [pbd_pkg::RUN_SENSES-1:0]   sense_level;
  wire [pbd_pkg::BIN_INPUTS-1:0]   bin_level;
  wire [pbd_pkg::FORCE_INPUTS-1:0] force_level;

  assign sense_level = pin_level[pbd_pkg::RUN_SENSES-1:0];
  assign bin_level   = pin_level[pbd_pkg::RUN_SENSES +: pbd_pkg::BIN_INPUTS];
  assign force_level = pin_level[pbd_pkg::RUN_SENSES + pbd_pkg::BIN_INPUTS +: pbd_pkg::FORCE_INPUTS];

  // delay settings, defaults held during reset
  pbd_pkg::pbd_delays_type delay_set;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      delay_set <= pbd_pkg::DELAYS_DEFAULT;
    end else begin
      delay_set <= delays;
    end
  end

  // engine running detection
  wire speed_above;
  wire oil_above;
  wire coolant_above;
  wire next_engine_running;

  assign speed_above         = measure.speed > thresholds.start_speed_threshold;
  assign oil_above           = measure.oil_pressure > thresholds.start_oil_pressure_threshold;
  assign coolant_above       = propulsion_application &&
                               (measure.coolant_pressure > thresholds.start_coolant_pressure_threshold);
  assign next_engine_running = speed_above || oil_above || coolant_above || (|sense_level);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      engine_running <= 1'b0;
    end else begin
      engine_running <= next_engine_running;
    end
  end

  // running-only group hold-off, armed only while running
  wire [pbd_pkg::DELAY_WIDTH-1:0] group_delay [pbd_pkg::RUN_GROUPS];

  assign group_delay[0] = delay_set.run_group_a_delay;
  assign group_delay[1] = delay_set.run_group_b_delay;
  assign group_delay[2] = delay_set.run_group_c_delay;

  for (genvar g = 0; g < pbd_pkg::RUN_GROUPS; g++) begin : g_group
    pbd_delay_timer #(.SEC_TICKS(SEC_TICKS)) u_timer (
      .clock (clock),
      .reset (reset),
      .arm   (engine_running),
      .delay (group_delay[g]),
      .done  (run_group_enable[g])
    );
  end

  // binary input protection filters
  wire [pbd_pkg::BIN_INPUTS-1:0]  bin_arm;
  wire [pbd_pkg::DELAY_WIDTH-1:0] bin_delay [pbd_pkg::BIN_INPUTS];

  for (genvar b = 0; b < pbd_pkg::BIN_INPUTS; b++) begin : g_bin
    wire [1:0] sel;
    assign sel          = bin_filter_select[2*b +: 2];
    assign bin_delay[b] = (sel == pbd_pkg::FILTER_SEL_A) ? delay_set.input_filter_delay_a :
                          (sel == pbd_pkg::FILTER_SEL_B) ? delay_set.input_filter_delay_b :
                                                           delay_set.input_filter_delay_c;
    assign bin_arm[b]   = bin_level[b] && bin_is_protection[b];
    pbd_delay_timer #(.SEC_TICKS(SEC_TICKS)) u_timer (
      .clock (clock),
      .reset (reset),
      .arm   (bin_arm[b]),
      .delay (bin_delay[b]),
      .done  (bin_protection_active[b])
    );
  end

  // logical function follows the filtered pin with no protection delay
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bin_logic_level <= '0;
    end else begin
      bin_logic_level <= bin_level;
    end
  end

  // forced inhibit: armed while input open, independent of running
  wire [pbd_pkg::FORCE_INPUTS-1:0] force_arm;
  wire [pbd_pkg::DELAY_WIDTH-1:0]  force_delay [pbd_pkg::FORCE_INPUTS];

  assign force_arm      = ~force_level;
  assign force_delay[0] = delay_set.forced_inhibit_delay_a;
  assign force_delay[1] = delay_set.forced_inhibit_delay_b;

  for (genvar f = 0; f < pbd_pkg::FORCE_INPUTS; f++) begin : g_force
    pbd_delay_timer #(.SEC_TICKS(SEC_TICKS)) u_timer (
      .clock (clock),
      .reset (reset),
      .arm   (force_arm[f]),
      .delay (force_delay[f]),
      .done  (forced_inhibit_active[f])
    );
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_group_hold_off: assert property (!engine_running |=> run_group_enable == '0)
    else $error("running-only group enabled while engine not running");

  a_speed_running: assert property (speed_above |=> engine_running)
    else $error("speed above threshold did not mark running");

  a_oil_running: assert property (oil_above |=> engine_running)
    else $error("oil pressure above threshold did not mark running");

  a_coolant_gated: assert property ((!propulsion_application && !speed_above && !oil_above && sense_level == '0)
    |=> !engine_running)
    else $error("coolant pressure counted outside propulsion application");

  a_coolant_running: assert property ((propulsion_application &&
    measure.coolant_pressure > thresholds.start_coolant_pressure_threshold) |=> engine_running)
    else $error("coolant pressure above threshold did not mark running");

  a_sense_running: assert property ((|sense_level) |=> engine_running)
    else $error("run sense input did not mark running");

  a_group_a_start: assert property ((engine_running && delay_set.run_group_a_delay == 6'h00)
    ##1 engine_running |-> run_group_enable[0])
    else $error("group a with zero delay not enabled");

  a_bin_not_prot: assert property (!bin_is_protection[0] |=> !bin_protection_active[0])
    else $error("binary protection active on non-protection input");

  a_bin_open_clear: assert property (!bin_level[0] |=> !bin_protection_active[0])
    else $error("binary protection active with input open");

  a_logic_undelayed: assert property (bin_level[1] |=> bin_logic_level[1])
    else $error("logical function delayed");

  a_force_remove: assert property (force_level[0] |=> !forced_inhibit_active[0])
    else $error("forced inhibit a not removed on closing");

  a_force_zero: assert property ((!force_level[1] && delay_set.forced_inhibit_delay_b == 6'h00)
    |=> forced_inhibit_active[1])
    else $error("forced inhibit b with zero delay not active");

  c_engine_starts: cover property ($rose(engine_running));
  c_group_c_on: cover property ($rose(run_group_enable[2]));
  c_bin_trip: cover property ($rose(bin_protection_active[0]));
  c_force_on: cover property ($rose(forced_inhibit_active[0]) && !engine_running);

endmodule

/* File: tb/pbd_sensor_model.sv */
/*
  engine sensor model: turns above or below requests into measured words.
  assumes every threshold is below 16'hFFFF so one step above it fits.
*/
`timescale 1ns/100ps
module pbd_sensor_model (
  input  pbd_pkg::pbd_threshold_type thresholds,
  input  wire logic [2:0]            above,
  output pbd_pkg::pbd_measure_type   measure
);
  // a below request sits exactly on the threshold, which must not count
  assign measure = {above[2] ? thresholds.start_speed_threshold + 16'h0001 : thresholds.start_speed_threshold,
    above[1] ? thresholds.start_oil_pressure_threshold + 16'h0001 : thresholds.start_oil_pressure_threshold,
    above[0] ? thresholds.start_coolant_pressure_threshold + 16'h0001 : thresholds.start_coolant_pressure_threshold};
endmodule

/* File: tb/tb_top.sv */
/*
  self-checking bench for the protection blocking delays block.
  assumes a short second of TK clocks and the sensor model beside the design.
*/
`timescale 1ns/100ps
module tb_top;
  localparam int TK = 4;
  logic                       clock, reset, propulsion_application, engine_running;
  logic [2:0]                 above, run_sense_input, run_group_enable;
  logic [3:0]                 bin_input, bin_is_protection, bin_protection_active, bin_logic_level;
  logic [7:0]                 bin_filter_select;
  logic [1:0]                 forced_inhibit_input, forced_inhibit_active;
  logic [13:0]                outs;
  pbd_pkg::pbd_measure_type   measure;
  pbd_pkg::pbd_threshold_type thresholds;
  pbd_pkg::pbd_delays_type    delays;
  integer                     seed = 88, error_cnt = 0, total_checks = 0;
  int                         first[14];
  int                         s, b, lat;

  assign outs = {forced_inhibit_active, bin_logic_level, bin_protection_active, run_group_enable, engine_running};

  pbd_sensor_model pbd_sensor_model_inst (.thresholds(thresholds), .above(above), .measure(measure));
  pbd_top #(.SEC_TICKS(TK)) pbd_top_inst (.clock(clock), .reset(reset), .measure(measure),
    .thresholds(thresholds), .delays(delays), .propulsion_application(propulsion_application),
    .run_sense_input(run_sense_input), .bin_input(bin_input), .bin_is_protection(bin_is_protection),
    .bin_filter_select(bin_filter_select), .forced_inhibit_input(forced_inhibit_input),
    .engine_running(engine_running), .run_group_enable(run_group_enable),
    .bin_protection_active(bin_protection_active), .bin_logic_level(bin_logic_level),
    .forced_inhibit_active(forced_inhibit_active));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  // records the cycle of the first change of every output bit
  task watch(input int n);
    logic [13:0] start;
    int          i, k;
    start = outs;
    for (k = 0; k < 14; k++) first[k] = -1;
    for (i = 1; i <= n; i++) begin
      @(posedge clock);
      #1;
      for (k = 0; k < 14; k++) if (first[k] < 0 && outs[k] !== start[k]) first[k] = i;
    end
    @(negedge clock);
  endtask

  task idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task drive_run(input int src, input logic v);
    case (src)
      0: above[2] = v;
      1: above[1] = v;
      2, 6: above[0] = v;
      default: run_sense_input[src-3] = v;
    endcase
  endtask

  function int rnd6();
    return $unsigned($random(seed)) % 6;
  endfunction

  function int eff(input logic [5:0] d);
    return (d > 6'h3C) ? 60 : int'(d);
  endfunction

  function int filt(input int i);
    case (bin_filter_select[2*i+:2])
      2'h0: return eff(delays.input_filter_delay_a);
      2'h1: return eff(delays.input_filter_delay_b);
      default: return eff(delays.input_filter_delay_c);
    endcase
  endfunction

  initial begin
    #(25 * 20000);
    error_cnt++;
    report_and_stop;
  end

  initial begin
    reset = 1'b1;
    above = 3'h0;
    run_sense_input = 3'h0;
    bin_input = 4'h0;
    bin_is_protection = 4'h0;
    bin_filter_select = 8'h00;
    forced_inhibit_input = 2'h3;
    propulsion_application = 1'b0;
    thresholds = 48'({$random(seed), $random(seed)}) & 48'h7FFF7FFF7FFF;
    delays = pbd_pkg::DELAYS_DEFAULT;
    idle(8);
    reset = 1'b0;
    @(posedge clock);
    #1;
    check("outputs after reset", outs, 14'h0000);
    @(negedge clock);
    for (s = 0; s < 7; s++) begin
      delays.run_group_a_delay = (s == 0) ? pbd_pkg::DELAY_MAX_S : 6'(rnd6());
      delays.run_group_b_delay = (s == 1) ? 6'h3F : 6'(rnd6());
      delays.run_group_c_delay = 6'(rnd6());
      propulsion_application = (s != 6);
      drive_run(s, 1'b1);
      idle(3);
      drive_run(s, 1'b0);
      idle(10);
      drive_run(s, 1'b1);
      watch(260);
      lat = (s > 2 && s < 6) ? 5 : 1;
      if (s == 6) check("coolant without propulsion", first[0], -1);
      else begin
        check("running rise", first[0], lat);
        check("group a rise", first[1], lat + eff(delays.run_group_a_delay) * TK + 1);
        check("group b rise", first[2], lat + eff(delays.run_group_b_delay) * TK + 1);
        check("group c rise", first[3], lat + eff(delays.run_group_c_delay) * TK + 1);
      end
      drive_run(s, 1'b0);
      watch(12);
      if (s != 6) begin
        check("running fall", first[0], lat);
        check("group a fall", first[1], lat + 1);
      end
      $display("run group test %0d done", s);
    end
    for (s = 0; s < 3; s++) begin
      delays.input_filter_delay_a = (s == 0) ? 6'h00 : 6'(rnd6());
      delays.input_filter_delay_b = 6'(rnd6());
      delays.input_filter_delay_c = 6'(rnd6());
      bin_filter_select = (s == 0) ? 8'hE4 : 8'($random(seed));
      bin_is_protection = (s == 0) ? 4'hF : 4'($random(seed));
      bin_input = 4'hF;
      idle(3);
      bin_input = 4'h0;
      idle(12);
      bin_input = 4'hF;
      watch(40);
      for (b = 0; b < 4; b++) begin
        check("logic level rise", first[8+b], 5);
        check("protection rise", first[4+b], bin_is_protection[b] ? filt(b) * TK + 5 : -1);
      end
      bin_input = 4'h0;
      watch(12);
      for (b = 0; b < 4; b++) begin
        check("logic level fall", first[8+b], 5);
        check("protection fall", first[4+b], bin_is_protection[b] ? 5 : -1);
      end
      $display("binary input test %0d done", s);
    end
    for (s = 0; s < 2; s++) begin
      delays.forced_inhibit_delay_a = 6'(rnd6());
      delays.forced_inhibit_delay_b = (s == 0) ? 6'h00 : 6'(rnd6());
      above[2] = s[0];
      idle(3);
      forced_inhibit_input = 2'h0;
      idle(3);
      forced_inhibit_input = 2'h3;
      idle(10);
      forced_inhibit_input = 2'h0;
      watch(40);
      check("inhibit a rise", first[12], eff(delays.forced_inhibit_delay_a) * TK + 5);
      check("inhibit b rise", first[13], eff(delays.forced_inhibit_delay_b) * TK + 5);
      forced_inhibit_input = 2'h3;
      watch(12);
      check("inhibit a fall", first[12], 5);
      check("inhibit b fall", first[13], 5);
      above = 3'h0;
      idle(10);
      $display("forced inhibit test %0d done", s);
    end
    report_and_stop;
  end
endmodule
